// >>> design/ccis_top.sv
/*
 * Contact input configuration/status register, attention logic,
 * per-channel debounce, watchdog and indicator drivers.
 * Assumes bus strobes are synchronous to ref_clk; field and supply
 * monitor inputs are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps

module ccis_top
    import ccis_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire logic                  bus_sel,
    input  wire logic                  bus_wr,
    input  wire logic [ADDR_W-1:0]     bus_addr,
    input  wire logic [DATA_W-1:0]     bus_wdata,
    output logic      [DATA_W-1:0]     bus_rdata,
    output logic                       bus_ack,
    output logic                       bus_attention,
    input  wire logic [N_CHANNELS-1:0] contact_closed,
    input  wire logic                  aux_supply_fail,
    input  wire logic                  ground_fault,
    output logic                       led_comm,
    output logic                       led_ext_fault,
    output logic                       led_int_fault,
    output logic      [N_CHANNELS-1:0] channel_point_indicators
);

    logic                  rst_meta;
    logic                  rst_n;
    logic [TICK_W-1:0]     tick_cnt;
    logic                  ms_tick;
    logic [2:0]            aux_sync;
    logic [2:0]            gf_sync;
    logic                  aux_q;
    logic                  gf_q;
    logic                  cfg_configured;
    logic                  cfg_force;
    logic                  cfg_gf_en;
    logic [WD_W-1:0]       wd_cnt;
    logic                  wd_timeout;
    logic [WD_W-1:0]       comm_cnt;
    logic                  access;
    logic                  cfg_hit;
    logic                  pt_hit;
    logic                  attention;
    logic [DATA_W-1:0]     status_word;
    logic [N_CHANNELS-1:0] pin_s1;
    logic [N_CHANNELS-1:0] pin_s2;
    logic [N_CHANNELS-1:0] pin_s3;

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // one millisecond enable
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            ms_tick  <= 1'b0;
        end else if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
            ms_tick  <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            ms_tick  <= 1'b0;
        end
    end

    // monitor inputs: change taken only when stages 2 and 3 agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_sync <= '0;
            gf_sync  <= '0;
            aux_q    <= 1'b0;
            gf_q     <= 1'b0;
        end else begin
            aux_sync <= {aux_sync[1:0], aux_supply_fail};
            gf_sync  <= {gf_sync[1:0], ground_fault};
            if (aux_sync[2] == aux_sync[1]) begin
                aux_q <= aux_sync[2];
            end
            if (gf_sync[2] == gf_sync[1]) begin
                gf_q <= gf_sync[2];
            end
        end
    end

    assign access  = bus_sel;
    assign cfg_hit = bus_sel && (bus_addr == CFG_STATUS_ADDR);
    assign pt_hit  = bus_sel && (bus_addr == POINT_DATA_ADDR);

    // configuration: only bits 0, 1 and 9 are stored
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_configured <= CONFIG_RESET;
            cfg_force      <= FORCE_RESET;
            cfg_gf_en      <= GF_EN_RESET;
        end else if (cfg_hit && bus_wr) begin
            cfg_configured <= bus_wdata[BIT_CONFIG];
            cfg_force      <= bus_wdata[BIT_FORCE];
            cfg_gf_en      <= bus_wdata[BIT_GF_EN];
        end
    end

    // watchdog: restarted by every access except one in the expiry cycle, where the timeout wins; a late access still sees the timeout
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt     <= WD_ZERO;
            wd_timeout <= 1'b0;
        end else if (ms_tick && !wd_timeout && (wd_cnt == WDOG_MS - WD_ONE)) begin
            wd_timeout <= 1'b1;
            wd_cnt     <= WD_ZERO;
        end else if (access) begin
            wd_cnt     <= WD_ZERO;
            wd_timeout <= 1'b0;
        end else if (ms_tick && !wd_timeout) begin
            wd_cnt <= wd_cnt + WD_ONE;
        end
    end

    // communications indicator held for a short while after each access
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            comm_cnt <= WD_ZERO;
            led_comm <= 1'b0;
        end else if (access) begin
            comm_cnt <= COMM_HOLD_MS;
            led_comm <= 1'b1;
        end else begin
            if (ms_tick && comm_cnt != WD_ZERO) begin
                comm_cnt <= comm_cnt - WD_ONE;
            end
            led_comm <= (comm_cnt != WD_ZERO);
        end
    end

    // fault indicators
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            led_ext_fault <= 1'b0;
            led_int_fault <= 1'b0;
        end else begin
            led_ext_fault <= gf_q;
            led_int_fault <= cfg_force || aux_q || wd_timeout;
        end
    end

    // ground fault only counts when enabled
    assign attention = !cfg_configured || cfg_force || aux_q || wd_timeout
                     || (cfg_gf_en && gf_q);

    always_comb begin
        status_word               = STATUS_ONES;
        status_word[BIT_CONFIG]   = cfg_configured;
        status_word[BIT_FORCE]    = cfg_force;
        status_word[BIT_AUX_FAIL] = aux_q;
        status_word[BIT_GF_EN]    = cfg_gf_en;
        status_word[BIT_GF]       = gf_q;
    end

    // bus answer one cycle after the strobe; config access works under attention
    // so that software can always recover the module
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_ack       <= 1'b0;
            bus_attention <= 1'b0;
            bus_rdata     <= ZERO_WORD;
        end else begin
            bus_ack       <= access;
            bus_attention <= access && attention && (cfg_hit || pt_hit);
            if (cfg_hit && !bus_wr) begin
                bus_rdata <= status_word;
            end else if (pt_hit && !bus_wr && !attention) begin
                bus_rdata <= channel_point_indicators;
            end else begin
                bus_rdata <= ZERO_WORD;
            end
        end
    end

    // contact inputs: three-stage sync, then per-channel debounce
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
        end else begin
            pin_s1 <= contact_closed;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // acceptance after 5 whole ticks: between 4 and 5 ms, inside the 3..7 ms window
    genvar ch;
    generate
        for (ch = 0; ch < N_CHANNELS; ch++) begin : g_chan
            logic [DEB_W-1:0] deb_cnt;
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    deb_cnt                      <= '0;
                    channel_point_indicators[ch] <= 1'b0;
                end else if ((pin_s2[ch] != pin_s3[ch])
                             || (pin_s3[ch] == channel_point_indicators[ch])) begin
                    deb_cnt <= '0;
                end else if (ms_tick) begin
                    if (deb_cnt == DEBOUNCE_MS - 3'h1) begin
                        deb_cnt                      <= '0;
                        channel_point_indicators[ch] <= pin_s3[ch];
                    end else begin
                        deb_cnt <= deb_cnt + 3'h1;
                    end
                end
            end
        end
    endgenerate

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic rd_status_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_status_q <= 1'b0;
        end else begin
            rd_status_q <= cfg_hit && !bus_wr;
        end
    end

    a_status_fixed_bits: assert property (
        rd_status_q |-> ((bus_rdata & STATUS_ONES) == STATUS_ONES) && !bus_rdata[6]
            && !bus_rdata[7])
        else $error("fixed status bits wrong");

    a_write_loads_cfg: assert property (
        (cfg_hit && bus_wr) |=> (cfg_configured == $past(bus_wdata[BIT_CONFIG]))
            && (cfg_force == $past(bus_wdata[BIT_FORCE]))
            && (cfg_gf_en == $past(bus_wdata[BIT_GF_EN])))
        else $error("configuration write not stored");

    a_status_mirror: assert property (
        (cfg_hit && !bus_wr) |=> bus_ack
            && (bus_rdata[BIT_CONFIG] == $past(cfg_configured))
            && (bus_rdata[BIT_FORCE] == $past(cfg_force))
            && (bus_rdata[BIT_GF_EN] == $past(cfg_gf_en))
            && (bus_rdata[BIT_AUX_FAIL] == $past(aux_q)))
        else $error("status word does not mirror state");

    a_unconf_attention: assert property (
        (pt_hit && !bus_wr && !cfg_configured) |=> bus_attention && (bus_rdata == ZERO_WORD))
        else $error("unconfigured point read gave data");

    a_gf_enabled_attn: assert property (
        (pt_hit && cfg_gf_en && gf_q) |=> bus_attention && (bus_rdata == ZERO_WORD))
        else $error("enabled ground fault did not block data");

    a_gf_masked: assert property (
        (pt_hit && !bus_wr && gf_q && !cfg_gf_en && cfg_configured && !cfg_force
            && !aux_q && !wd_timeout)
            |=> !bus_attention && (bus_rdata == $past(channel_point_indicators)))
        else $error("masked ground fault blocked data");

    a_ext_led_follow: assert property (
        rd_status_q |-> (bus_rdata[BIT_GF] == $past(gf_q)) && (led_ext_fault == $past(gf_q)))
        else $error("external fault indicator disagrees with status");

    a_int_led_attn: assert property (
        (led_int_fault && pt_hit && !$rose(cfg_force) && !$fell(aux_q))
            ##0 (cfg_force || aux_q || wd_timeout) |=> bus_attention)
        else $error("internal fault without attention");

    a_watchdog_expiry: assert property (
        (ms_tick && !wd_timeout && !access && (wd_cnt == WDOG_MS - WD_ONE))
            |=> wd_timeout ##1 led_int_fault)
        else $error("watchdog expiry not flagged");

    a_comm_led: assert property (
        access |=> led_comm)
        else $error("communications indicator not lit on access");

    a_debounce_tick: assert property (
        (channel_point_indicators != $past(channel_point_indicators)) |-> $past(ms_tick))
        else $error("point indicator changed off tick");

    a_ack_follows_sel: assert property (
        bus_ack == $past(bus_sel))
        else $error("acknowledge not one cycle after strobe");

    a_unmapped_quiet: assert property (
        (bus_sel && !cfg_hit && !pt_hit) |=> !bus_attention && (bus_rdata == ZERO_WORD))
        else $error("unmapped access gave data or attention");

    a_write_rdata_zero: assert property (
        (bus_sel && bus_wr) |=> (bus_rdata == ZERO_WORD))
        else $error("write answered with data");

    a_force_attention: assert property (
        (pt_hit && cfg_force) |=> bus_attention && (bus_rdata == ZERO_WORD))
        else $error("forced error without attention");

    a_cfg_write_only: assert property (
        !(cfg_hit && bus_wr) |=> $stable(cfg_configured) && $stable(cfg_force)
            && $stable(cfg_gf_en))
        else $error("configuration moved without a write");

    a_aux_sync_agree: assert property (
        $changed(aux_q) |-> $past(aux_sync[2] == aux_sync[1]))
        else $error("supply status taken before stages agree");

    a_gf_sync_agree: assert property (
        $changed(gf_q) |-> $past(gf_sync[2] == gf_sync[1]))
        else $error("ground fault taken before stages agree");

    a_ext_led_level: assert property (
        led_ext_fault == $past(gf_q))
        else $error("external fault indicator off its source");

    a_int_led_level: assert property (
        led_int_fault == $past(cfg_force || aux_q || wd_timeout))
        else $error("internal fault indicator off its sources");

    a_timeout_cleared: assert property (
        (access && wd_timeout) |=> !wd_timeout)
        else $error("watchdog timeout not cleared by access");

    a_comm_led_off: assert property (
        (!access && (comm_cnt == WD_ZERO)) |=> !led_comm)
        else $error("communications indicator lit while idle");

    a_point_data_clean: assert property (
        (pt_hit && !bus_wr && !attention)
            |=> !bus_attention && (bus_rdata == $past(channel_point_indicators)))
        else $error("clean point read lost data");

endmodule

// >>> design/ccis_pkg.sv
/*
 * Constants for the contact input configuration and status block:
 * word addresses, status field positions, reset values and timing.
 * Assumes a 50 MHz reference clock and a word-addressed I/O bus.
 */
// What this block does
// - one word address: write loads configuration, read returns status.
// - configure bit clears at reset; unconfigured point reads answer attention.
// - status bit 0 mirrors configure bit; writing 0 unconfigures and raises attention.
// - force error bit resets to 0; while set, attention; status bit 1 mirrors it.
// - undefined status bits 2-5 and 11-15 always read 1.
// - writes only affect configuration bits 0, 1 and 9.
// - status bit 8 shows auxiliary supply failure.
// - ground fault attention enable resets 0, written, read back at bit 9.
// - enable set and ground fault: point and config accesses answer attention; point reads give no data.
// - enable clear: ground fault neither raises attention nor blocks data.
// - status bit 10 shows field wiring ground fault.
// - external fault indicator follows status bit 10.
// - internal fault indicator on force, supply failure or watchdog; raises attention.
// - watchdog expires when controller stops accessing; counts as internal fault.
// - communications indicator lit while the controller is accessing.
// - sixteen point indicators follow debounced contact closure.
// - changes under 3 ms rejected, over 7 ms accepted.
package ccis_pkg;
    localparam int          N_CHANNELS      = 16;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;

    localparam logic [7:0]  CFG_STATUS_ADDR = 8'h0d;
    localparam logic [7:0]  POINT_DATA_ADDR = 8'h00;

    localparam int          BIT_CONFIG      = 0;
    localparam int          BIT_FORCE       = 1;
    localparam int          BIT_AUX_FAIL    = 8;
    localparam int          BIT_GF_EN       = 9;
    localparam int          BIT_GF          = 10;
    // undefined bits 2-5, 11-15 read high
    localparam logic [15:0] STATUS_ONES     = 16'hf83c;
    localparam logic [15:0] ZERO_WORD       = 16'h0000;

    localparam logic        CONFIG_RESET    = 1'b0;
    localparam logic        FORCE_RESET     = 1'b0;
    localparam logic        GF_EN_RESET     = 1'b0;

    localparam int          CLK_PERIOD_NS   = 20;
    localparam int          MS_NS           = 1000000;
    localparam int          MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
    localparam int          TICK_W          = 16;

    localparam int          DEB_W           = 3;
    localparam logic [2:0]  DEBOUNCE_MS     = 3'h5;
    localparam int          WD_W            = 8;
    localparam logic [7:0]  WDOG_MS         = 8'h64;
    localparam logic [7:0]  COMM_HOLD_MS    = 8'h14;
    localparam logic [7:0]  WD_ZERO         = 8'h00;
    localparam logic [7:0]  WD_ONE          = 8'h01;
endpackage

// >>> testbench/ccis_ctrl_model.sv
/*
 * Controller model on the module I/O bus: one-cycle access strobes
 * with the answer picked up just after the same edge that takes the strobe.
 * Assumes the block answers every access exactly one edge later.
 */
`timescale 1ns/10ps

module ccis_ctrl_model
    import ccis_pkg::*;
(
    input  wire logic              ref_clk,
    output logic                   bus_sel,
    output logic                   bus_wr,
    output logic [ADDR_W-1:0]      bus_addr,
    output logic [DATA_W-1:0]      bus_wdata,
    input  wire logic [DATA_W-1:0] bus_rdata,
    input  wire logic              bus_ack,
    input  wire logic              bus_attention
);
    initial begin
        bus_sel   = 1'b0;
        bus_wr    = 1'b0;
        bus_addr  = 8'hff;
        bus_wdata = 16'h0000;
    end

    // strobe is a single-cycle pulse, so the answer is taken as it lands
    task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] data,
                          output logic [15:0] rdata, output logic att, output logic ack);
        @(posedge ref_clk);
        #1;
        bus_sel   = 1'b1;
        bus_wr    = wr;
        bus_addr  = addr;
        bus_wdata = data;
        @(posedge ref_clk);
        #1;
        bus_sel   = 1'b0;
        // released lines carry inverted junk so stale values never match
        bus_wr    = ~wr;
        bus_addr  = ~addr;
        bus_wdata = ~data;
        ack       = bus_ack;
        rdata     = bus_rdata;
        att       = bus_attention;
    endtask
endmodule

// >>> testbench/contact_input_config_status_test.sv
/*
 * Self-checking bench: register accesses through the controller model,
 * field inputs driven directly, indicators and answers compared.
 * Assumes a shortened ms tick of 20 cycles for all timing.
 */
`timescale 1ns/10ps

module contact_input_config_status_test
    import ccis_pkg::*;
;
    localparam int TK = 20;
    logic                  ref_clk;
    logic                  reset_n;
    logic                  bus_sel;
    logic                  bus_wr;
    logic [ADDR_W-1:0]     bus_addr;
    logic [DATA_W-1:0]     bus_wdata;
    logic [DATA_W-1:0]     bus_rdata;
    logic                  bus_ack;
    logic                  bus_attention;
    logic [N_CHANNELS-1:0] contact_closed;
    logic                  aux_supply_fail;
    logic                  ground_fault;
    logic                  led_comm;
    logic                  led_ext_fault;
    logic                  led_int_fault;
    logic [N_CHANNELS-1:0] chan;
    logic [15:0]           rd;
    logic                  at;
    logic                  ak;
    int                    bad_count;
    int                    check_count;

    ccis_top #(.TICK_CYCLES(TK)) u_ccis_top (
        .ref_clk(ref_clk), .reset_n(reset_n), .bus_sel(bus_sel), .bus_wr(bus_wr),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_ack(bus_ack), .bus_attention(bus_attention), .contact_closed(contact_closed),
        .aux_supply_fail(aux_supply_fail), .ground_fault(ground_fault),
        .led_comm(led_comm), .led_ext_fault(led_ext_fault), .led_int_fault(led_int_fault),
        .channel_point_indicators(chan)
    );

    ccis_ctrl_model u_ccis_ctrl_model (
        .ref_clk(ref_clk), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
        .bus_attention(bus_attention)
    );

    always #10 ref_clk = ~ref_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk1(input logic seen, input logic exp);
        check({15'h0000, seen}, {15'h0000, exp});
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d,
                       input logic [15:0] exp, input logic exp_att);
        u_ccis_ctrl_model.access(wr, a, d, rd, at, ak);
        chk1(ak, 1'b1);
        check(rd, exp);
        chk1(at, exp_att);
    endtask

    // field inputs pass a 3-flop synchroniser, so allow a few edges
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        give_verdict();
    end

    initial begin
        ref_clk         = 1'b0;
        reset_n         = 1'b0;
        contact_closed  = 16'h0000;
        aux_supply_fail = 1'b0;
        ground_fault    = 1'b0;
        bad_count       = 0;
        check_count     = 0;
        settle(4);
        reset_n = 1'b1;
        settle(2);
        chk1(led_comm, 1'b0);
        acc(1'b0, CFG_STATUS_ADDR, 16'h0000, 16'hf83c, 1'b1);
        chk1(led_comm, 1'b1);
        acc(1'b0, POINT_DATA_ADDR, 16'h0000, 16'h0000, 1'b1);
        acc(1'b1, CFG_STATUS_ADDR, 16'hffff, 16'h0000, 1'b1);
        acc(1'b0, CFG_STATUS_ADDR, 16'h0000, 16'hfa3f, 1'b1);
        chk1(led_int_fault, 1'b1);
        acc(1'b0, POINT_DATA_ADDR, 16'h0000, 16'h0000, 1'b1);
        acc(1'b1, CFG_STATUS_ADDR, 16'h0001, 16'h0000, 1'b1);
        acc(1'b0, CFG_STATUS_ADDR, 16'h0000, 16'hf83d, 1'b0);
        acc(1'b1, CFG_STATUS_ADDR, 16'h0000, 16'h0000, 1'b0);
        acc(1'b0, POINT_DATA_ADDR, 16'h0000, 16'h0000, 1'b1);
        acc(1'b1, CFG_STATUS_ADDR, 16'h0001, 16'h0000, 1'b1);
        acc(1'b1, 8'h05, 16'h1234, 16'h0000, 1'b0);
        acc(1'b0, 8'h05, 16'h0000, 16'h0000, 1'b0);
        acc(1'b0, CFG_STATUS_ADDR, 16'h0000, 16'hf83d, 1'b0);
        contact_closed = 16'ha5c3;
        settle(8 * TK);
        check(chan, 16'ha5c3);
        acc(1'b0, POINT_DATA_ADDR, 16'h0000, 16'ha5c3, 1'b0);
        // short glitch on every channel must not reach the indicators
        contact_closed = 16'h5a3c;
        settle(2 * TK);
        check(chan, 16'ha5c3);
        contact_closed = 16'ha5c3;
        settle(8 * TK);
        check(chan, 16'ha5c3);
        aux_supply_fail = 1'b1;
        settle(8);
        acc(1'b0, CFG_STATUS_ADDR, 16'h0000, 16'hf93d, 1'b1);
        chk1(led_int_fault, 1'b1);
        aux_supply_fail = 1'b0;
        settle(8);
        acc(1'b0, CFG_STATUS_ADDR, 16'h0000, 16'hf83d, 1'b0);
        chk1(led_int_fault, 1'b0);
        ground_fault = 1'b1;
        settle(8);
        acc(1'b0, CFG_STATUS_ADDR, 16'h0000, 16'hfc3d, 1'b0);
        chk1(led_ext_fault, 1'b1);
        acc(1'b0, POINT_DATA_ADDR, 16'h0000, 16'ha5c3, 1'b0);
        acc(1'b1, CFG_STATUS_ADDR, 16'h0201, 16'h0000, 1'b0);
        acc(1'b0, CFG_STATUS_ADDR, 16'h0000, 16'hfe3d, 1'b1);
        acc(1'b0, POINT_DATA_ADDR, 16'h0000, 16'h0000, 1'b1);
        ground_fault = 1'b0;
        settle(8);
        chk1(led_ext_fault, 1'b0);
        acc(1'b0, POINT_DATA_ADDR, 16'h0000, 16'ha5c3, 1'b0);
        settle(25 * TK);
        chk1(led_comm, 1'b0);
        chk1(led_int_fault, 1'b0);
        settle(80 * TK);
        chk1(led_int_fault, 1'b1);
        acc(1'b0, CFG_STATUS_ADDR, 16'h0000, 16'hfa3d, 1'b1);
        acc(1'b0, POINT_DATA_ADDR, 16'h0000, 16'ha5c3, 1'b0);
        chk1(led_int_fault, 1'b0);
        give_verdict();
    end
endmodule
